// File: rtl/bpcr_pkg.sv
// Package of constants for the bridge primary command register block.
// Assumes a single 100 MHz clock domain and a dword configuration port.
package bpcr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] BPCR_CMD_OFF   = 12'h004;
  localparam logic [15:0] BPCR_CMD_RST   = 16'h0000;

  // ****************************************
  // Command field positions
  // ****************************************
  localparam int BPCR_IO_EN_BIT   = 0;
  localparam int BPCR_MEM_EN_BIT  = 1;
  localparam int BPCR_BM_EN_BIT   = 2;
  localparam int BPCR_SPC_BIT     = 3;
  localparam int BPCR_MWI_BIT     = 4;
  localparam int BPCR_VGA_BIT     = 5;
  localparam int BPCR_PERR_BIT    = 6;
  localparam int BPCR_WAIT_BIT    = 7;
  localparam int BPCR_SERR_BIT    = 8;
  localparam int BPCR_FBB_BIT     = 9;
  localparam int BPCR_INTD_BIT    = 10;

  // Writable bits in each bridge direction.
  localparam logic [15:0] BPCR_WMASK_FWD = 16'h0147;
  localparam logic [15:0] BPCR_WMASK_REV = 16'h0567;

  // ****************************************
  // Palette snoop decode
  // ****************************************
  localparam logic [9:0] BPCR_VGA_A0 = 10'h3C6;
  localparam logic [9:0] BPCR_VGA_A1 = 10'h3C8;
  localparam logic [9:0] BPCR_VGA_A2 = 10'h3C9;

  localparam int BPCR_INT_LINES = 4;

endpackage

// File: rtl/bpcr_pri_decode.sv
// Primary-side claim decode for the bridge command register block.
// Assumes request strobes are on the same clock as the command register.
`timescale 1ns/100ps

module bpcr_pri_decode (
  input  wire logic        io_en,
  input  wire logic        mem_en,
  input  wire logic        vga_en,
  input  wire logic        io_req,
  input  wire logic        io_wr,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_in_range,
  input  wire logic        mem_rd_req,
  input  wire logic        mem_in_range,
  output wire logic        io_claim,
  output wire logic        vga_claim,
  output wire logic        mem_claim
);
  import bpcr_pkg::*;

  wire logic [9:0] low_addr;
  wire logic       vga_hit;

  assign low_addr  = io_addr[9:0];
  // Only the low ten bits are compared, so every ISA alias matches.
  assign vga_hit   = (low_addr == BPCR_VGA_A0) || (low_addr == BPCR_VGA_A1)
                     || (low_addr == BPCR_VGA_A2);                  // [R7]
  assign vga_claim = vga_en && io_req && io_wr && vga_hit;           // [R7]
  assign io_claim  = io_en && io_req && io_in_range;                 // [R1]
  assign mem_claim = mem_en && mem_rd_req && mem_in_range;           // [R2]

endmodule

// File: rtl/bpcr_cmd_reg.sv
// Primary command register of a transparent bridge, with the gating that
// its bits apply. Assumes configuration accesses and transaction requests
// come from logic on ref_clk; the bridge direction and primary bus mode
// are pins and are synchronised here.
`timescale 1ns/100ps

// Operation
// (R1) With bit 0 clear, primary I/O transactions are ignored; it resets to 0. Palette writes under R7 are still claimed.
// (R2) With bit 1 clear, primary memory reads are ignored, else accepted.
// (R3) With bit 2 clear, no primary mastering and no secondary response.
// (R4) A reverse bridge on a PCI-X primary may start split completions anyway.
// (R5) Bit 3 reads zero and special cycles are never claimed.
// (R6) Bit 4 reads zero and only forwarded write-and-invalidate is issued.
// (R7) In reverse mode bit 5 claims palette writes at 3C6h, 3C8h and 3C9h.
// (R8) Bit 6 gates the setting of master data parity error; traffic goes on.
// (R9) Bit 7 is unsupported and reads zero.
// (R10) In forward mode error messages go out only while bit 8 is set.
// (R11) In reverse mode the system error line is driven only while bit 8 is set.
// (R12) Bit 9 is unsupported and reads zero.
// (R13) In reverse mode bit 10 blocks all four legacy interrupt lines.
// (R14) Bits 15:11 read zero, and bits 5 and 10 read zero in forward mode.
module bpcr_cmd_reg (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        reverse_pin,
  input  wire logic        pri_pcix_pin,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rd_valid,
  input  wire logic        pri_io_req,
  input  wire logic        pri_io_wr,
  input  wire logic [15:0] pri_io_addr,
  input  wire logic        pri_io_in_range,
  input  wire logic        pri_mem_rd_req,
  input  wire logic        pri_mem_in_range,
  input  wire logic        pri_spc_req,
  output logic             pri_io_claim,
  output logic             pri_mem_claim,
  output logic             pri_spc_claim,
  input  wire logic        fwd_mst_req,
  input  wire logic        fwd_mwi,
  input  wire logic        split_cpl_req,
  output logic             pri_mst_start,
  output logic             pri_mwi_cmd,
  output logic             pri_split_start,
  input  wire logic        sec_req,
  output logic             sec_claim,
  input  wire logic        par_err_evt,
  output logic             mdpe_set,
  input  wire logic        sys_err_evt,
  output logic             err_msg_send,
  output logic             serr_out,
  input  wire logic [3:0]  int_req,
  output logic      [3:0]  int_out_b,
  output logic      [15:0] cmd_value
);
  import bpcr_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] rev_sync_ff;
  logic [1:0] pcix_sync_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rev_sync_ff  <= 2'h0;
      pcix_sync_ff <= 2'h0;
    end else begin
      rev_sync_ff  <= {rev_sync_ff[0], reverse_pin};
      pcix_sync_ff <= {pcix_sync_ff[0], pri_pcix_pin};
    end
  end

  wire logic rev_mode;
  wire logic pcix_mode;

  assign rev_mode  = rev_sync_ff[1];
  assign pcix_mode = pcix_sync_ff[1];

  // ****************************************
  // Command register
  // ****************************************
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;

  wire logic        cmd_hit;
  wire logic [15:0] wmask;
  wire logic [15:0] be_mask;
  wire logic [15:0] cmd_eff;

  assign cmd_hit = cfg_addr == BPCR_CMD_OFF;
  // Bits writable in neither direction never load, so they stay at their zero reset value.
  assign wmask   = rev_mode ? BPCR_WMASK_REV : BPCR_WMASK_FWD; // [R5] [R6]
  assign be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign nxt_cmd = (cfg_wr && cmd_hit)
                   ? ((cmd_ff & ~(wmask & be_mask))
                      | (cfg_wdata[15:0] & wmask & be_mask))
                   : cmd_ff;                       // [R9] [R12] [R14]
  // Reverse-only bits read and act as zero while the bridge runs forward.
  assign cmd_eff = cmd_ff & wmask;                                  // [R14]

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmd_ff <= BPCR_CMD_RST;                                  // [R1] [R2]
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  wire logic io_en;
  wire logic mem_en;
  wire logic bm_en;
  wire logic vga_en;
  wire logic perr_en;
  wire logic serr_en;
  wire logic int_dis;

  assign io_en   = cmd_eff[BPCR_IO_EN_BIT];
  assign mem_en  = cmd_eff[BPCR_MEM_EN_BIT];
  assign bm_en   = cmd_eff[BPCR_BM_EN_BIT];
  assign vga_en  = cmd_eff[BPCR_VGA_BIT] && rev_mode;               // [R7]
  assign perr_en = cmd_eff[BPCR_PERR_BIT];
  assign serr_en = cmd_eff[BPCR_SERR_BIT];
  assign int_dis = cmd_eff[BPCR_INTD_BIT] && rev_mode;              // [R13]

  // ****************************************
  // Primary target decode
  // ****************************************
  wire logic io_claim_w;
  wire logic vga_claim_w;
  wire logic mem_claim_w;

  bpcr_pri_decode u_decode (
    .io_en        (io_en),
    .mem_en       (mem_en),
    .vga_en       (vga_en),
    .io_req       (pri_io_req),
    .io_wr        (pri_io_wr),
    .io_addr      (pri_io_addr),
    .io_in_range  (pri_io_in_range),
    .mem_rd_req   (pri_mem_rd_req),
    .mem_in_range (pri_mem_in_range),
    .io_claim     (io_claim_w),
    .vga_claim    (vga_claim_w),
    .mem_claim    (mem_claim_w)
  );

  // ****************************************
  // Gated actions
  // ****************************************
  wire logic nxt_io_claim;
  wire logic nxt_mst_start;
  wire logic nxt_mwi;
  wire logic nxt_split;
  wire logic nxt_sec_claim;
  wire logic nxt_mdpe;
  wire logic nxt_err_msg;
  wire logic nxt_serr;
  wire logic [3:0] nxt_int_b;

  assign nxt_io_claim  = io_claim_w || vga_claim_w;            // [R1] [R7]
  assign nxt_mst_start = bm_en && fwd_mst_req;                      // [R3]
  // Write-and-invalidate only passes through for another master's request.
  assign nxt_mwi       = nxt_mst_start && fwd_mwi && !pcix_mode;    // [R6]
  assign nxt_split     = split_cpl_req
                         && (bm_en || (rev_mode && pcix_mode));     // [R4]
  assign nxt_sec_claim = bm_en && sec_req;                          // [R3]
  // Parity errors never stall traffic; only the status report is gated.
  assign nxt_mdpe      = perr_en && par_err_evt;                    // [R8]
  assign nxt_err_msg   = !rev_mode && serr_en && sys_err_evt;       // [R10]
  assign nxt_serr      = rev_mode && serr_en && sys_err_evt;        // [R11]
  assign nxt_int_b     = ~(int_req & {BPCR_INT_LINES{rev_mode && !int_dis}});

  // ****************************************
  // Read-back
  // ****************************************
  wire logic [31:0] nxt_rdata;

  assign nxt_rdata = cmd_hit ? {16'h0000, cmd_eff} : 32'h00000000;

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_rdata       <= 32'h00000000;
      cfg_rd_valid    <= 1'b0;
      pri_io_claim    <= 1'b0;
      pri_mem_claim   <= 1'b0;
      pri_spc_claim   <= 1'b0;
      pri_mst_start   <= 1'b0;
      pri_mwi_cmd     <= 1'b0;
      pri_split_start <= 1'b0;
      sec_claim       <= 1'b0;
      mdpe_set        <= 1'b0;
      err_msg_send    <= 1'b0;
      serr_out        <= 1'b0;
      int_out_b       <= 4'hF;
      cmd_value       <= BPCR_CMD_RST;
    end else begin
      cfg_rdata       <= cfg_rd ? nxt_rdata : 32'h00000000;
      cfg_rd_valid    <= cfg_rd;
      pri_io_claim    <= nxt_io_claim;
      pri_mem_claim   <= mem_claim_w;
      pri_spc_claim   <= 1'b0 & pri_spc_req;                      // [R5]
      pri_mst_start   <= nxt_mst_start;
      pri_mwi_cmd     <= nxt_mwi;
      pri_split_start <= nxt_split;
      sec_claim       <= nxt_sec_claim;
      mdpe_set        <= nxt_mdpe;
      err_msg_send    <= nxt_err_msg;
      serr_out        <= nxt_serr;
      int_out_b       <= nxt_int_b;                                 // [R13]
      cmd_value       <= cmd_eff;
    end
  end

endmodule

// File: dv/bpcr_cmd_reg_asserts.sv
// Port checks of the primary command register.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
// ****
// Checker
// ****
module bpcr_cmd_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        cfg_rd,
  input wire logic        cfg_rd_valid,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        pri_io_req,
  input wire logic        pri_io_in_range,
  input wire logic        pri_io_claim,
  input wire logic        pri_mem_rd_req,
  input wire logic        pri_mem_in_range,
  input wire logic        pri_mem_claim,
  input wire logic        pri_spc_claim,
  input wire logic        fwd_mst_req,
  input wire logic        pri_mst_start,
  input wire logic        par_err_evt,
  input wire logic        mdpe_set,
  input wire logic        err_msg_send,
  input wire logic        serr_out,
  input wire logic [3:0]  int_out_b,
  input wire logic [15:0] cmd_value
);
  import bpcr_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd_hit;
    cfg_rd && cfg_addr == BPCR_CMD_OFF;
  endsequence
  sequence s_rd_ans;
    cfg_rd_valid && cfg_rdata == {16'h0000, cmd_value};
  endsequence
  AST_RD: assert property (s_rd_hit |=> s_rd_ans)
    else $error("command read data wrong");
  AST_RO: assert property ((cmd_value & ~BPCR_WMASK_REV) == 16'h0000)
    else $error("read-only command bits set");
  AST_SPC: assert property (!pri_spc_claim)
    else $error("special cycle claimed");
  AST_IO: assert property (pri_io_req && pri_io_in_range |=>
                           pri_io_claim || !cmd_value[0])
    else $error("io request not claimed");
  AST_IOQ: assert property (!pri_io_req |=> !pri_io_claim)
    else $error("io claim without request");
  AST_MEM: assert property (pri_mem_rd_req && pri_mem_in_range |=>
                            pri_mem_claim == cmd_value[1])
    else $error("memory claim wrong");
  AST_MST: assert property (fwd_mst_req |=>
                            pri_mst_start == cmd_value[2])
    else $error("master start wrong");
  AST_PE: assert property (##1 mdpe_set ==
                           ($past(par_err_evt) && cmd_value[6]))
    else $error("parity status request wrong");
  AST_SE: assert property (!cmd_value[8] |->
                           !(err_msg_send || serr_out))
    else $error("error report while disabled");
  AST_INT: assert property (cmd_value[10] |-> int_out_b == 4'hF)
    else $error("interrupt line not blocked");
endmodule
bind bpcr_cmd_reg bpcr_cmd_asserts chk_u (.*);

// File: dv/bpcr_host_mdl.sv
// Configuration host model for the command register.
// Assumes read data arrives one cycle after the request edge.
`timescale 1ns/100ps
// ****
// Host
// ****
module bpcr_host_mdl (
  input  wire logic        ref_clk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rd_valid,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic      [11:0] cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  initial begin
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // Released lines show the inverse of their last value.
  task automatic drop();
    {cfg_addr, cfg_be, cfg_wdata} = ~{cfg_addr, cfg_be, cfg_wdata};
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
    @(posedge ref_clk);
    #1;
    cfg_wr = 1'b0;
    drop();
  endtask
  task automatic rd(input logic [11:0] a, output logic [32:0] v);
    @(posedge ref_clk);
    #1;
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(posedge ref_clk);
    #1;
    cfg_rd = 1'b0;
    drop();
    v = {cfg_rd_valid, cfg_rdata};
  endtask
endmodule

// File: dv/tb_top.sv
// Random testbench of the primary command register.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/100ps
// ****
// Bench
// ****
module tb_top;
  import bpcr_pkg::*;
  logic        ref_clk, rst_b, reverse_pin, pri_pcix_pin, cfg_wr, cfg_rd;
  logic        cfg_rd_valid, pri_io_req, pri_io_wr, pri_io_in_range;
  logic        pri_mem_rd_req, pri_mem_in_range, pri_spc_req, fwd_mst_req;
  logic        fwd_mwi, split_cpl_req, sec_req, par_err_evt, sys_err_evt;
  logic        pri_io_claim, pri_mem_claim, pri_spc_claim, pri_mst_start;
  logic        pri_mwi_cmd, pri_split_start, sec_claim, mdpe_set;
  logic        err_msg_send, serr_out;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be, int_req, int_out_b;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [15:0] pri_io_addr, cmd_value, st, cur;
  logic [32:0] rv;
  logic [9:0]  pal_tab [4] = '{10'h3C6, 10'h3C8, 10'h3C9, 10'h3C7};
  integer      seed, fail_count, num_checks, m;
  integer      cyc = 0;
  bpcr_cmd_reg  dut_u (.*);
  bpcr_host_mdl host_u (.*);
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] eff(input logic [15:0] d, input logic r);
    eff = d & (r ? 16'h0567 : 16'h0147);
  endfunction
  function automatic logic [13:0] ev_exp(input logic [15:0] c,
                                         input logic r, input logic p);
    logic pal;
    logic ms;
    pal = pri_io_addr[9:0] inside {10'h3C6, 10'h3C8, 10'h3C9};
    ms = c[2] & fwd_mst_req;
    ev_exp = {(c[0] & pri_io_req & pri_io_in_range)
              | (r & c[5] & pri_io_req & pri_io_wr & pal),
              c[1] & pri_mem_rd_req & pri_mem_in_range, 1'b0, ms,
              ms & fwd_mwi & ~p, split_cpl_req & (c[2] | (r & p)),
              c[2] & sec_req, c[6] & par_err_evt, ~r & c[8] & sys_err_evt,
              r & c[8] & sys_err_evt, ~(int_req & {4{r & ~c[10]}})};
  endfunction
  task automatic ev_step();
    logic [13:0] e;
    logic [13:0] g;
    {pri_io_req, pri_io_wr, pri_io_in_range, pri_mem_rd_req, pri_mem_in_range,
     pri_spc_req, fwd_mst_req, fwd_mwi, split_cpl_req, sec_req, par_err_evt,
     sys_err_evt, int_req, pri_io_addr} = $random(seed);
    if (pri_io_addr[15]) pri_io_addr[9:0] = pal_tab[pri_io_addr[1:0]];
    e = ev_exp(cur, reverse_pin, pri_pcix_pin);
    @(posedge ref_clk);
    #1;
    g = {pri_io_claim, pri_mem_claim, pri_spc_claim, pri_mst_start,
         pri_mwi_cmd, pri_split_start, sec_claim, mdpe_set, err_msg_send,
         serr_out, int_out_b};
    chk(33'(g), 33'(e));
  endtask
  task automatic cw(input logic [15:0] d, input logic [3:0] b);
    logic [15:0] k;
    k = eff({{8{b[1]}}, {8{b[0]}}}, reverse_pin);
    host_u.wr(BPCR_CMD_OFF, b, {16'h0000, d});
    st = (st & ~k) | (d & k);
    cur = eff(st, reverse_pin);
  endtask
  task automatic cr(input logic [11:0] a, input logic [15:0] e);
    host_u.rd(a, rv);
    chk(rv, {17'h10000, e});
  endtask
  initial begin
    seed = 32'h45164AB6;
    {fail_count, num_checks, st, cur} = '0;
    {rst_b, reverse_pin, pri_pcix_pin, pri_io_req, pri_io_wr} = '0;
    {pri_io_in_range, pri_mem_rd_req, pri_mem_in_range, pri_spc_req} = '0;
    {fwd_mst_req, fwd_mwi, split_cpl_req, sec_req, par_err_evt} = '0;
    {sys_err_evt, int_req, pri_io_addr} = '0;
    repeat (20) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk(33'(int_out_b), 33'h0000F);
    cr(BPCR_CMD_OFF, 16'h0000);
    $display("test reset done");
    for (m = 0; m < 4; m = m + 1) begin
      {pri_pcix_pin, reverse_pin} = 2'(m);
      repeat (4) @(posedge ref_clk);
      cur = eff(st, reverse_pin);
      cw(16'hFFFF, 4'h3);
      cr(BPCR_CMD_OFF, cur);
      cw(16'h0000, 4'h2);
      host_u.wr(12'h008, 4'hF, 32'hFFFFFFFF);
      cr(BPCR_CMD_OFF, cur);
      cr(12'h008, 16'h0000);
      repeat (30) begin
        cw(16'($random(seed)), 4'($random(seed)));
        cr(BPCR_CMD_OFF, cur);
        repeat (4) ev_step();
      end
      $display("test mode %0d done", m);
    end
    cw(16'hFFFF, 4'h3);
    rst_b = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    {st, cur} = '0;
    chk(33'({cmd_value, int_out_b}), 33'h0000F);
    cr(BPCR_CMD_OFF, 16'h0000);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
